// ==== tb/epc_core_model.sv ====
// Core model: takes offered exceptions and signals handler return.
// Assumes the controller clock; the bench gates acks and returns.
`timescale 1ns/1ps
module epc_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       excRequest,
  input  wire logic [5:0] excNumber,
  input  wire logic       ackEn,
  input  wire logic       doReturn,
  output logic            takeAck,
  output logic            handlerReturn,
  output logic [5:0]      lastTaken,
  output logic [7:0]      takenCnt
);
  // One ack per request; ackEn low models a slow core
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      takeAck       <= 1'b0;
      handlerReturn <= 1'b0;
      lastTaken     <= 6'h00;
      takenCnt      <= 8'h00;
    end else begin
      takeAck       <= excRequest && ackEn && !takeAck;
      handlerReturn <= doReturn;
      if (takeAck && excRequest) begin
        lastTaken <= excNumber;
        takenCnt  <= takenCnt + 8'h01;
      end
    end
  end
endmodule

// ==== tb/test_exception_priority_controller.sv ====
// Self-checking bench for the exception priority controller.
// Assumes epc_pkg and the core model are compiled first.
`timescale 1ns/1ps
module test_exception_priority_controller import epc_pkg::*;;
  logic                 clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic                 faultEvent, svcCall, takeAck, handlerReturn, excRequest;
  logic                 irqOut, ackEn, doReturn, slvErr;
  logic [7:0]           paddr, takenCnt;
  logic [31:0]          pwdata, prdata, rd;
  logic [NUM_LINES-1:0] lines;
  logic [5:0]           excNumber, activeStatus, lastTaken;
  int                   error_cnt, cmp_count, k, j;

  epc_exception_priority_controller epc_exception_priority_controller_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .peripheralRequestLines(lines), .faultEvent(faultEvent),
    .supervisorCallInstruction(svcCall), .takeAck(takeAck),
    .handlerReturn(handlerReturn), .excRequest(excRequest), .excNumber(excNumber),
    .activeExceptionStatus(activeStatus), .irqOut(irqOut));
  epc_core_model epc_core_model_i (
    .clk(clk), .rst_n(rst_n), .excRequest(excRequest), .excNumber(excNumber),
    .ackEn(ackEn), .doReturn(doReturn), .takeAck(takeAck),
    .handlerReturn(handlerReturn), .lastTaken(lastTaken), .takenCnt(takenCnt));

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle cycle after it avoids double drives
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic waitReq();
    int i;
    i = 0;
    while (excRequest !== 1'b1 && i < 60) begin
      @(posedge clk);
      i++;
    end
    if (i >= 60) error_cnt++;
  endtask

  // Offer check, core accept, then status readback
  task automatic take(input logic [5:0] n);
    int i;
    logic [7:0] c;
    c = takenCnt;
    i = 0;
    waitReq();
    chk(32'(excNumber), 32'(n));
    ackEn <= 1'b1;
    while (takenCnt === c && i < 40) begin
      @(posedge clk);
      i++;
    end
    if (i >= 40) error_cnt++;
    ackEn <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(activeStatus), 32'(n));
    chk(32'(lastTaken), 32'(n));
  endtask

  task automatic ret();
    doReturn <= 1'b1;
    @(posedge clk);
    doReturn <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic noreq();
    repeat (20) begin
      @(posedge clk);
      chk(32'(excRequest), 32'h0);
    end
  endtask

  function automatic logic [5:0] lineNum(int i);
    return EXC_LINE0 + 6'(i);
  endfunction

  // All lines at lowest level except line b at the highest
  function automatic logic [31:0] priWord(int r, int b);
    logic [31:0] w;
    w = 32'hFFFFFFFF;
    if (b / 16 == r) w[2*(b%16) +: 2] = 2'h0;
    return w;
  endfunction

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lines = '0;
    faultEvent = 1'b0;
    svcCall = 1'b0;
    ackEn = 1'b0;
    doReturn = 1'b0;
    void'($urandom(32'h2a39));
    k = $urandom_range(31, 0);
    j = (k + 1 + $urandom_range(14, 0)) % 32;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    take(EXC_RESET);
    rdchk(ADDR_ACTIVE, 32'h1);
    chk(32'(irqOut), 32'h0);
    rdchk(ADDR_EVSTAT, 32'h1);
    wr(ADDR_EVEN, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irqOut), 32'h1);
    wr(ADDR_EVCLR, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irqOut), 32'h0);
    rdchk(8'h40, 32'h0);
    chk(32'(slvErr), 32'h1);
    ret();
    $display("reset and registers done");
    // Level line, global enable still off
    wr(ADDR_ENABLE, 32'hFFFFFFFF);
    lines[k] <= 1'b1;
    noreq();
    wr(ADDR_CTRL, 32'h1);
    take(lineNum(k));
    ret();
    take(lineNum(k));
    lines[k] <= 1'b0;
    repeat (4) @(posedge clk);
    ret();
    noreq();
    $display("level done");
    wr(ADDR_EDGE, 32'h1 << j);
    lines[j] <= 1'b1;
    take(lineNum(j));
    ret();
    noreq();
    lines[j] <= 1'b0;
    repeat (4) @(posedge clk);
    lines[j] <= 1'b1;
    take(lineNum(j));
    ret();
    lines[j] <= 1'b0;
    $display("edge done");
    // Equal levels, then a fault on top
    wr(ADDR_LPRI0, 32'h55555555);
    wr(ADDR_LPRI1, 32'h55555555);
    lines[k] <= 1'b1;
    lines[j] <= 1'b1;
    repeat (4) @(posedge clk);
    waitReq();
    chk(32'(excNumber), 32'(lineNum(k < j ? k : j)));
    faultEvent <= 1'b1;
    @(posedge clk);
    faultEvent <= 1'b0;
    repeat (3) @(posedge clk);
    take(EXC_FAULT);
    lines <= '0;
    repeat (4) @(posedge clk);
    ret();
    take(lineNum(j));
    ret();
    $display("priority done");
    wr(ADDR_EDGE, 32'h0);
    wr(ADDR_LPRI0, priWord(0, j));
    wr(ADDR_LPRI1, priWord(1, j));
    wr(ADDR_SYSPRI, 32'h0C);
    lines[k] <= 1'b1;
    take(lineNum(k));
    lines[j] <= 1'b1;
    take(lineNum(j));
    wr(ADDR_CTRL, 32'h5);
    noreq();
    lines[j] <= 1'b0;
    repeat (4) @(posedge clk);
    ret();
    chk(32'(activeStatus), 32'(lineNum(k)));
    lines[k] <= 1'b0;
    repeat (4) @(posedge clk);
    ret();
    take(EXC_PEND);
    ret();
    $display("preempt done");
    svcCall <= 1'b1;
    @(posedge clk);
    svcCall <= 1'b0;
    take(EXC_SVC);
    ret();
    wr(ADDR_TRELOAD, 32'h20);
    wr(ADDR_CTRL, 32'h3);
    take(EXC_TICK);
    wr(ADDR_CTRL, 32'h1);
    ret();
    $display("system exceptions done");
    report_and_stop();
  end
endmodule

// ==== verilog/epc_exception_priority_controller.sv ====
// Exception and interrupt front end with APB registers.
// Assumes the core acks each taken exception and signals handler return.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module epc_exception_priority_controller
  import epc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic [NUM_LINES-1:0] peripheralRequestLines,
  input  wire logic                 faultEvent,
  input  wire logic                 supervisorCallInstruction,
  input  wire logic                 takeAck,
  input  wire logic                 handlerReturn,
  output logic                      excRequest,
  output logic [5:0]                excNumber,
  output logic [5:0]                activeExceptionStatus,
  output logic                      irqOut
);
  // Pin synchroniser, two stages; only stage two is read
  logic [NUM_LINES-1:0] syncA, syncB, lineLast;
  always_ff @(posedge clk) begin
    syncA <= peripheralRequestLines;
    syncB <= syncA;
  end

  // Software state
  logic        globalEn, resetPend, faultPend, svcPend, pendSvPend, tickPend;
  logic        tickEn;
  logic [NUM_LINES-1:0] lineEn, lineEdge, edgePend, lineActive;
  logic [23:0] tickReload, tickCount;
  logic [1:0]  priSvc, priPend, priTick;
  logic [63:0] linePri;
  logic [5:0]  activeNum;
  logic [2:0]  activePri;
  logic [2:0]  excPri;
  logic [15:0] stackNum [0:7];
  logic [2:0]  stackPri [0:7];
  logic [3:0]  depth;
  logic [2:0]  evStat, evEn;

  wire wrEn = psel && penable && pwrite;
  wire rdEn = psel && penable && !pwrite;

  // Edge lines latch one request per rising edge; level lines follow the pin
  wire [NUM_LINES-1:0] riseSeen = syncB & ~lineLast;
  wire [NUM_LINES-1:0] lineReq  = (lineEdge & edgePend) | (~lineEdge & syncB);
  wire [NUM_LINES-1:0] lineOk   = lineReq & lineEn & ~lineActive & {NUM_LINES{globalEn}};

  // Priority of each line as internal code
  function automatic logic [2:0] progPri(input logic [1:0] p);
    progPri = PRI_BASE + {1'b0, p};
  endfunction

  // Winner search: lower code wins, ties kept by lowest number except that lines beat system sources
  logic [2:0] bestPri;
  logic [5:0] bestNum;
  always_comb begin
    bestPri = PRI_IDLE;
    bestNum = 6'h00;
    if (tickPend && progPri(priTick) < bestPri) begin
      bestPri = progPri(priTick);
      bestNum = EXC_TICK;
    end
    if (pendSvPend && progPri(priPend) <= bestPri) begin
      bestPri = progPri(priPend);
      bestNum = EXC_PEND;
    end
    if (svcPend && progPri(priSvc) <= bestPri) begin
      bestPri = progPri(priSvc);
      bestNum = EXC_SVC;
    end
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (lineOk[i] && progPri(linePri[2*i +: 2]) <= bestPri) begin
        bestPri = progPri(linePri[2*i +: 2]);
        bestNum = EXC_LINE0 + 6'(i);
      end
    end
    // Lines rank above tick and service on ties, fixed ones overrule all
    if (faultPend) begin
      bestPri = PRI_FAULT;
      bestNum = EXC_FAULT;
    end
    if (resetPend) begin
      bestPri = PRI_RESET;
      bestNum = EXC_RESET;
    end
  end
  // Service order above may pick a line over an equal-priority system one;
  // lowest number wins, so re-check system sources after lines
  logic [2:0] winPri;
  logic [5:0] winNum;
  always_comb begin
    winPri = bestPri;
    winNum = bestNum;
    if (!resetPend && !faultPend) begin
      if (tickPend && progPri(priTick) == bestPri && bestNum > EXC_TICK)
        winNum = EXC_TICK;
      if (pendSvPend && progPri(priPend) == bestPri && EXC_PEND < winNum)
        winNum = EXC_PEND;
      if (svcPend && progPri(priSvc) == bestPri && EXC_SVC < winNum)
        winNum = EXC_SVC;
    end
  end
  wire preempt = (winPri < activePri) && (depth < 4'h8);

  // Tick timer counts down and pends on wrap
  wire tickFire = tickEn && (tickCount == 24'h000001);
  always_ff @(posedge clk) begin
    if (!rst_n)
      tickCount <= TICK_RESET;
    else if (wrEn && paddr == ADDR_TCOUNT)
      tickCount <= TICK_RESET;
    else if (tickEn)
      tickCount <= (tickCount == 24'h000000 || tickFire) ? tickReload
                                                         : tickCount - 24'h000001;
  end

  // Edge latches: hardware set wins over the clear by acknowledge
  wire accept = excRequest && takeAck;
  wire [5:0] accIdx = excNumber - EXC_LINE0;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lineLast <= '0;
      edgePend <= '0;
    end else begin
      lineLast <= syncB;
      for (int i = 0; i < NUM_LINES; i++)
        if (riseSeen[i])
          edgePend[i] <= 1'b1;
        else if (accept && excNumber >= EXC_LINE0 && accIdx == 6'(i))
          edgePend[i] <= 1'b0;
    end
  end

  // System pending flags; acceptance clears, new event wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resetPend  <= 1'b1;
      faultPend  <= 1'b0;
      svcPend    <= 1'b0;
      pendSvPend <= 1'b0;
      tickPend   <= 1'b0;
    end else begin
      if (accept && excNumber == EXC_RESET)
        resetPend <= 1'b0;
      faultPend <= faultEvent | (faultPend & ~(accept && excNumber == EXC_FAULT));
      svcPend   <= supervisorCallInstruction
                   | (svcPend & ~(accept && excNumber == EXC_SVC));
      tickPend  <= tickFire | (tickPend & ~(accept && excNumber == EXC_TICK));
      if (wrEn && paddr == ADDR_CTRL && pwdata[2])
        pendSvPend <= 1'b1;
      else if (accept && excNumber == EXC_PEND)
        pendSvPend <= 1'b0;
    end
  end

  // Nesting stack of active handlers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      depth      <= 4'h0;
      activeNum  <= 6'h00;
      activePri  <= PRI_IDLE;
      lineActive <= '0;
    end else if (accept) begin
      stackNum[depth[2:0]] <= {10'h000, activeNum};
      stackPri[depth[2:0]] <= activePri;
      depth     <= depth + 4'h1;
      activeNum <= excNumber;
      // Priority offered with the number, not a newer winner's
      activePri <= excPri;
      if (excNumber >= EXC_LINE0)
        lineActive[accIdx[4:0]] <= 1'b1;
    end else if (handlerReturn && depth != 4'h0) begin
      // Level line re-pends here if still high
      depth     <= depth - 4'h1;
      activeNum <= stackNum[depth[2:0] - 3'h1][5:0];
      activePri <= stackPri[depth[2:0] - 3'h1];
      if (activeNum >= EXC_LINE0)
        lineActive[activeNum[4:0] - 5'h10] <= 1'b0;
    end
  end

  // Request to the core, recomputed each cycle from preempt and dropped the cycle after acknowledge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      excRequest <= 1'b0;
      excNumber  <= 6'h00;
      excPri     <= PRI_IDLE;
    end else begin
      excRequest <= preempt && !accept;
      excNumber  <= winNum;
      excPri     <= winPri;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n)
      activeExceptionStatus <= 6'h00;
    else
      activeExceptionStatus <= activeNum;
  end

  // Events: any exception accepted, fault raised; nesting overflow bit never sets, as preempt needs depth below 8
  wire [2:0] evSet = {preempt && depth == 4'h8, faultEvent, accept};
  always_ff @(posedge clk) begin
    if (!rst_n)
      evStat <= 3'h0;
    else
      evStat <= evSet | (evStat & ~((wrEn && paddr == ADDR_EVCLR) ? pwdata[2:0] : 3'h0));
  end
  always_ff @(posedge clk) begin
    if (!rst_n)
      irqOut <= 1'b0;
    else
      irqOut <= |(evStat & evEn);
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      globalEn   <= 1'b0;
      tickEn     <= 1'b0;
      lineEn     <= '0;
      lineEdge   <= '0;
      tickReload <= TICK_RESET;
      priSvc     <= 2'h0;
      priPend    <= 2'h3;
      priTick    <= 2'h3;
      linePri    <= '0;
      evEn       <= 3'h0;
    end else if (wrEn) begin
      unique case (paddr)
        ADDR_CTRL: begin
          globalEn <= pwdata[0];
          tickEn   <= pwdata[1];
        end
        ADDR_ENABLE:  lineEn     <= pwdata;
        ADDR_EDGE:    lineEdge   <= pwdata;
        ADDR_TRELOAD: tickReload <= pwdata[23:0];
        ADDR_SYSPRI: begin
          priSvc  <= pwdata[1:0];
          priPend <= pwdata[3:2];
          priTick <= pwdata[5:4];
        end
        ADDR_LPRI0: linePri[31:0]  <= pwdata;
        ADDR_LPRI1: linePri[63:32] <= pwdata;
        ADDR_EVEN:  evEn <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read mux and APB answer, zero wait states
  logic [31:0] rdMux;
  always_comb begin
    unique case (paddr)
      ADDR_CTRL:    rdMux = {29'h0, pendSvPend, tickEn, globalEn};
      ADDR_ENABLE:  rdMux = lineEn;
      ADDR_EDGE:    rdMux = lineEdge;
      ADDR_PEND:    rdMux = lineReq;
      ADDR_ACTIVE:  rdMux = {26'h0, activeNum};
      ADDR_TRELOAD: rdMux = {8'h00, tickReload};
      ADDR_TCOUNT:  rdMux = {8'h00, tickCount};
      ADDR_SYSPRI:  rdMux = {26'h0, priTick, priPend, priSvc};
      ADDR_LPRI0:   rdMux = linePri[31:0];
      ADDR_LPRI1:   rdMux = linePri[63:32];
      ADDR_EVSTAT:  rdMux = {29'h0, evStat};
      ADDR_EVEN:    rdMux = {29'h0, evEn};
      default:      rdMux = 32'h00000000;
    endcase
  end
  wire unmapped = (paddr > ADDR_EVEN) || (paddr[1:0] != 2'h0);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
      prdata  <= (psel && !penable) ? rdMux : prdata;
    end
  end

  // Checks
  property p_edge_once;
    @(posedge clk) disable iff (!rst_n)
      (lineEdge[0] && edgePend[0] && !riseSeen[0] && !accept) |=> edgePend[0];
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge request lost");
  property p_rise_sets;
    @(posedge clk) disable iff (!rst_n) riseSeen[0] |=> edgePend[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise not latched");
  property p_level;
    @(posedge clk) disable iff (!rst_n)
      (!lineEdge[1] && syncB[1]) |-> lineReq[1];
  endproperty
  a_level: assert property (p_level) else $error("level line not pending");
  property p_reset_first;
    @(posedge clk) disable iff (!rst_n) resetPend |-> winNum == EXC_RESET;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("reset not chosen");
  property p_fault;
    @(posedge clk) disable iff (!rst_n)
      (faultPend && !resetPend) |-> winNum == EXC_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not chosen");
  property p_gate;
    @(posedge clk) disable iff (!rst_n) !globalEn |-> lineOk == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("line passed disabled");
  property p_status;
    @(posedge clk) disable iff (!rst_n) accept |=> ##1 activeExceptionStatus == $past(excNumber, 2);
  endproperty
  a_status: assert property (p_status) else $error("status wrong");
  property p_preempt;
    @(posedge clk) disable iff (!rst_n) excRequest |-> $past(preempt);
  endproperty
  a_preempt: assert property (p_preempt) else $error("request without preempt");
endmodule

// ==== verilog/epc_pkg.sv ====
// Constants for the exception priority controller.
// Assumes one 250 MHz core clock and an APB register port.
// Operation
// - Level input re-raises while line stays high
// - Rising edge input raises one request
// - Held-high edge line needs clearing first
// - Reset is number 1, fixed priority -3
// - Hard fault is number 3, priority -1
// - Supervisor call raises number 11, programmable
// - Pendable service 14, after higher work
// - 24-bit tick timer raises number 15
// - Thirty-two lines take numbers 16 to 47
// - Peripheral index plus sixteen gives number
// - Only reset and fault have fixed priority
// - Active number readable in status field
// - Accepted exception redirects core to handler
// - Higher priority request preempts running handler
// - Peripheral needs source and global enable
package epc_pkg;
  localparam int        NUM_LINES   = 32;
  localparam logic [5:0] EXC_RESET  = 6'h01;
  localparam logic [5:0] EXC_FAULT  = 6'h03;
  localparam logic [5:0] EXC_SVC    = 6'h0B;
  localparam logic [5:0] EXC_PEND   = 6'h0E;
  localparam logic [5:0] EXC_TICK   = 6'h0F;
  localparam logic [5:0] EXC_LINE0  = 6'h10;
  // Priority codes: fixed ones sit below all programmable levels 3..6
  localparam logic [2:0] PRI_RESET  = 3'h0;
  localparam logic [2:0] PRI_FAULT  = 3'h2;
  localparam logic [2:0] PRI_BASE   = 3'h3;
  localparam logic [2:0] PRI_IDLE   = 3'h7;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_ENABLE  = 8'h04;
  localparam logic [7:0] ADDR_EDGE    = 8'h08;
  localparam logic [7:0] ADDR_PEND    = 8'h0C;
  localparam logic [7:0] ADDR_ACTIVE  = 8'h10;
  localparam logic [7:0] ADDR_TRELOAD = 8'h14;
  localparam logic [7:0] ADDR_TCOUNT  = 8'h18;
  localparam logic [7:0] ADDR_SYSPRI  = 8'h1C;
  localparam logic [7:0] ADDR_LPRI0   = 8'h20;
  localparam logic [7:0] ADDR_LPRI1   = 8'h24;
  localparam logic [7:0] ADDR_EVSTAT  = 8'h28;
  localparam logic [7:0] ADDR_EVCLR   = 8'h2C;
  localparam logic [7:0] ADDR_EVEN    = 8'h30;
  localparam logic [23:0] TICK_RESET = 24'h000000;
endpackage
